// *** sle_pkg.sv ***
package sle_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_LANES = 8;
  localparam int CNT_W = 8;
  localparam int NUM_ERR_TYPES = 3;
  localparam int NUM_LANE_REGS = 7;
  localparam int ADDR_W = 14;

  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [11:0] IDX_DISP_LANES = 12'h046D;
  localparam logic [11:0] IDX_NIT_LANES = 12'h046E;
  localparam logic [11:0] IDX_UCC_LANES = 12'h046F;
  localparam logic [11:0] IDX_CODE_GRP_LANES = 12'h0470;
  localparam logic [11:0] IDX_FRAME_LANES = 12'h0471;
  localparam logic [11:0] IDX_CHECKSUM_LANES = 12'h0472;
  localparam logic [11:0] IDX_LANE_ALIGN_LANES = 12'h0473;
  localparam logic [11:0] IDX_SUMMARY = 12'h047A;
  localparam logic [11:0] IDX_SYNC_SELECT = 12'h047B;
  localparam logic [11:0] IDX_THRESHOLD = 12'h047C;

  // ****************************************
  // Slot of each per-lane sticky register
  // ****************************************
  localparam int SLOT_CODE_GRP = 0;
  localparam int SLOT_FRAME = 1;
  localparam int SLOT_CHECKSUM = 2;
  localparam int SLOT_LANE_ALIGN = 3;
  localparam int SLOT_DISP = 4;
  localparam int SLOT_NIT = 5;
  localparam int SLOT_UCC = 6;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SUM_DISP = 7;
  localparam int SUM_NIT = 6;
  localparam int SUM_UCC = 5;
  localparam int SUM_RESERVED = 4;
  localparam int SUM_LANE_ALIGN = 3;
  localparam int SUM_CHECKSUM = 2;
  localparam int SUM_FRAME = 1;
  localparam int SUM_CODE_GRP = 0;
  localparam int SEL_DISP = 7;
  localparam int SEL_NIT = 6;
  localparam int SEL_UCC = 5;
  localparam int SEL_CMM = 4;
  localparam int SEL_CMM_EN = 3;

  // ****************************************
  // Reset values and write masks
  // ****************************************
  localparam logic [7:0] THRESHOLD_RST = 8'hFF;
  localparam logic [7:0] SELECT_RST = 8'h08;
  localparam logic [7:0] SELECT_RW_BITS = 8'hE8;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MASK_RW_BITS = 8'hEF;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  // Counted error strobes of one lane
  typedef struct packed {
    logic ucc;
    logic nit;
    logic disp;
  } sle_lane_err_t;

  // Sync failure strobes for all lanes
  typedef struct packed {
    logic [NUM_LANES-1:0] lane_align;
    logic [NUM_LANES-1:0] checksum;
    logic [NUM_LANES-1:0] frame;
    logic [NUM_LANES-1:0] code_grp;
  } sle_sync_fail_t;
endpackage

// *** sle_lane_err_cnt.sv ***
`timescale 1ns/1ps
module sle_lane_err_cnt import sle_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire sle_lane_err_t i_err,
  input wire sle_lane_err_t i_clear,
  input wire logic [CNT_W-1:0] i_threshold,
  output sle_lane_err_t o_reached
);
  logic [NUM_ERR_TYPES-1:0] err_bits;
  logic [NUM_ERR_TYPES-1:0] clr_bits;
  logic [NUM_ERR_TYPES-1:0] reached_bits;

  assign err_bits = i_err;
  assign clr_bits = i_clear;
  assign o_reached = reached_bits;

  // ****************************************
  // One saturating counter per error type
  // ****************************************
  genvar k;
  generate
    for (k = 0; k < NUM_ERR_TYPES; k++) begin : g_cnt
      logic [CNT_W-1:0] cnt_reg;
      logic [CNT_W-1:0] cnt_next;

      // Clear wins over a new error so software restarts from zero
      always_comb begin
        cnt_next = cnt_reg;
        if (clr_bits[k]) begin
          cnt_next = '0;
        end else if (err_bits[k] && cnt_reg != CNT_MAX) begin
          cnt_next = cnt_reg + 8'h01;
        end
      end

      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end

      // Compare against the shared threshold
      assign reached_bits[k] = (cnt_reg >= i_threshold);
    end
  endgenerate
endmodule

// *** sle_irq_sync.sv ***
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - Set control-character summary flag when its count reaches threshold on any lane.
// - Set lane-alignment summary bit 3 when initial alignment fails on any lane.
// - Set checksum summary bit 2 when any lane sees a bad checksum.
// - Set frame-alignment summary bit 1 when frame sync fails on any lane.
// - Set code-group summary bit 0 when code group sync fails on any lane.
// - Disparity resync enable bit 7 raises resync request at threshold.
// - Invalid-symbol resync enable bit 6 raises resync request at threshold.
// - Control-character resync enable bit 5 raises resync request at threshold.
// - Latched mismatch bit holds until software writes one to clear it or clears enable bit 3.
// - With enable low, mismatch bit neither latches nor affects the interrupt.
// - Mismatch enable bit 3 allows interrupts on configuration mismatch.
// - Count three error types per lane against 8-bit threshold, reset all ones.
// - Set mask bit plus matching failure pulls active-low interrupt low.
module sle_irq_sync import sle_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire sle_sync_fail_t I_SYNC_FAIL,
  input wire logic [NUM_LANES-1:0] I_DISP_ERR,
  input wire logic [NUM_LANES-1:0] I_NIT_ERR,
  input wire logic [NUM_LANES-1:0] I_UCC_ERR,
  input wire logic I_CONFIG_MISMATCH,
  output logic O_IRQ_N,
  output logic O_RESYNC_REQUEST
);
  // ****************************************
  // Address decode
  // ****************************************
  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  // One-hot hit on the seven per-lane sticky registers
  function automatic logic [NUM_LANE_REGS-1:0] lane_reg_hit(input logic [ADDR_W-1:0] a);
    lane_reg_hit = '0;
    lane_reg_hit[SLOT_CODE_GRP] = (a == byte_addr(IDX_CODE_GRP_LANES));
    lane_reg_hit[SLOT_FRAME] = (a == byte_addr(IDX_FRAME_LANES));
    lane_reg_hit[SLOT_CHECKSUM] = (a == byte_addr(IDX_CHECKSUM_LANES));
    lane_reg_hit[SLOT_LANE_ALIGN] = (a == byte_addr(IDX_LANE_ALIGN_LANES));
    lane_reg_hit[SLOT_DISP] = (a == byte_addr(IDX_DISP_LANES));
    lane_reg_hit[SLOT_NIT] = (a == byte_addr(IDX_NIT_LANES));
    lane_reg_hit[SLOT_UCC] = (a == byte_addr(IDX_UCC_LANES));
  endfunction

  logic wr_access;
  logic rd_setup;
  logic [NUM_LANE_REGS-1:0] wr_lane_hit;
  logic [7:0] wr_byte;

  // Zero wait states: every access phase completes at once
  assign O_PREADY = I_PSEL & I_PENABLE;
  assign wr_access = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign wr_lane_hit = wr_access ? lane_reg_hit(I_PADDR) : '0;
  assign wr_byte = I_PWDATA[7:0];

  // ****************************************
  // Per-lane error counters
  // ****************************************
  logic [7:0] threshold_reg;
  logic [NUM_LANES-1:0] disp_reached;
  logic [NUM_LANES-1:0] nit_reached;
  logic [NUM_LANES-1:0] ucc_reached;

  genvar ln;
  generate
    for (ln = 0; ln < NUM_LANES; ln++) begin : g_lane
      sle_lane_err_t err_in;
      sle_lane_err_t clr_in;
      sle_lane_err_t reached;

      assign err_in = '{ucc: I_UCC_ERR[ln], nit: I_NIT_ERR[ln], disp: I_DISP_ERR[ln]};
      // Clearing a lane's sticky bit restarts its counter too
      assign clr_in = '{ucc: wr_lane_hit[SLOT_UCC] & wr_byte[ln],
                        nit: wr_lane_hit[SLOT_NIT] & wr_byte[ln],
                        disp: wr_lane_hit[SLOT_DISP] & wr_byte[ln]};

      sle_lane_err_cnt u_cnt (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_err(err_in),
        .i_clear(clr_in),
        .i_threshold(threshold_reg),
        .o_reached(reached)
      );

      assign disp_reached[ln] = reached.disp;
      assign nit_reached[ln] = reached.nit;
      assign ucc_reached[ln] = reached.ucc;
    end
  endgenerate

  // ****************************************
  // Sticky per-lane status and summary flags
  // ****************************************
  logic [7:0] lane_sticky_reg [NUM_LANE_REGS];
  logic [7:0] lane_sticky_next [NUM_LANE_REGS];
  logic [7:0] lane_event [NUM_LANE_REGS];
  logic [7:0] summary;

  always_comb begin
    lane_event[SLOT_CODE_GRP] = I_SYNC_FAIL.code_grp;
    lane_event[SLOT_FRAME] = I_SYNC_FAIL.frame;
    lane_event[SLOT_CHECKSUM] = I_SYNC_FAIL.checksum;
    lane_event[SLOT_LANE_ALIGN] = I_SYNC_FAIL.lane_align;
    // A lane clear also zeroes its counter; the old reached level must not re-set the bit
    lane_event[SLOT_DISP] = disp_reached & ~(wr_lane_hit[SLOT_DISP] ? wr_byte : 8'h00);
    lane_event[SLOT_NIT] = nit_reached & ~(wr_lane_hit[SLOT_NIT] ? wr_byte : 8'h00);
    lane_event[SLOT_UCC] = ucc_reached & ~(wr_lane_hit[SLOT_UCC] ? wr_byte : 8'h00);
  end

  // Write one clears, but a new sync failure in the same cycle wins
  always_comb begin
    for (int r = 0; r < NUM_LANE_REGS; r++) begin
      lane_sticky_next[r] = (lane_sticky_reg[r] & ~(wr_lane_hit[r] ? wr_byte : 8'h00))
                            | lane_event[r];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int r = 0; r < NUM_LANE_REGS; r++) begin
        lane_sticky_reg[r] <= '0;
      end
    end else begin
      for (int r = 0; r < NUM_LANE_REGS; r++) begin
        lane_sticky_reg[r] <= lane_sticky_next[r];
      end
    end
  end

  // Summary is the OR of each lane register, so it follows lane clears
  always_comb begin
    summary = '0;
    summary[SUM_DISP] = |lane_sticky_reg[SLOT_DISP];
    summary[SUM_NIT] = |lane_sticky_reg[SLOT_NIT];
    summary[SUM_UCC] = |lane_sticky_reg[SLOT_UCC];
    summary[SUM_RESERVED] = 1'b0;
    summary[SUM_LANE_ALIGN] = |lane_sticky_reg[SLOT_LANE_ALIGN];
    summary[SUM_CHECKSUM] = |lane_sticky_reg[SLOT_CHECKSUM];
    summary[SUM_FRAME] = |lane_sticky_reg[SLOT_FRAME];
    summary[SUM_CODE_GRP] = |lane_sticky_reg[SLOT_CODE_GRP];
  end

  // ****************************************
  // Control registers and mismatch latch
  // ****************************************
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] select_reg;
  logic [7:0] select_next;
  logic [7:0] threshold_next;
  logic cmm_reg;
  logic cmm_next;
  logic mismatch_d_reg;
  logic mismatch_rise;
  logic config_mismatch_irq_enable;
  logic wr_summary;
  logic wr_select;

  assign wr_summary = wr_access & (I_PADDR == byte_addr(IDX_SUMMARY));
  assign wr_select = wr_access & (I_PADDR == byte_addr(IDX_SYNC_SELECT));
  assign config_mismatch_irq_enable = select_reg[SEL_CMM_EN];
  assign mismatch_rise = I_CONFIG_MISMATCH & ~mismatch_d_reg;

  always_comb begin
    mask_next = mask_reg;
    select_next = select_reg;
    threshold_next = threshold_reg;
    // Writes to the summary word land in the mask; reserved bit stays zero
    if (wr_summary) begin
      mask_next = wr_byte & MASK_RW_BITS;
    end
    if (wr_select) begin
      select_next = wr_byte & SELECT_RW_BITS;
    end
    if (wr_access && I_PADDR == byte_addr(IDX_THRESHOLD)) begin
      threshold_next = wr_byte;
    end
    // Latch on rising mismatch only while enabled; set beats clear
    if (!config_mismatch_irq_enable) begin
      cmm_next = 1'b0;
    end else if (mismatch_rise) begin
      cmm_next = 1'b1;
    end else if (wr_select && wr_byte[SEL_CMM]) begin
      cmm_next = 1'b0;
    end else begin
      cmm_next = cmm_reg;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mask_reg <= MASK_RST;
      select_reg <= SELECT_RST;
      threshold_reg <= THRESHOLD_RST;
      cmm_reg <= 1'b0;
      mismatch_d_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      select_reg <= select_next;
      threshold_reg <= threshold_next;
      cmm_reg <= cmm_next;
      mismatch_d_reg <= I_CONFIG_MISMATCH;
    end
  end

  // ****************************************
  // Interrupt and resync outputs
  // ****************************************
  logic irq_n_next;
  logic resync_next;

  // Registered outputs trail the flags by one clock to stay glitch free
  always_comb begin
    irq_n_next = ~(|(summary & mask_reg) | cmm_reg);
    resync_next = (select_reg[SEL_DISP] & summary[SUM_DISP])
                | (select_reg[SEL_NIT] & summary[SUM_NIT])
                | (select_reg[SEL_UCC] & summary[SUM_UCC]);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ_N <= 1'b1;
      O_RESYNC_REQUEST <= 1'b0;
    end else begin
      O_IRQ_N <= irq_n_next;
      O_RESYNC_REQUEST <= resync_next;
    end
  end

  // ****************************************
  // Read data, captured in the setup phase
  // ****************************************
  logic [31:0] prdata_next;
  logic slverr_reg;
  logic slverr_next;
  logic [NUM_LANE_REGS-1:0] rd_lane_hit;

  assign rd_lane_hit = lane_reg_hit(I_PADDR);

  always_comb begin
    prdata_next = O_PRDATA;
    slverr_next = slverr_reg;
    if (I_PSEL && !I_PENABLE) begin
      prdata_next = '0;
      slverr_next = 1'b0;
      if (|rd_lane_hit) begin
        for (int r = 0; r < NUM_LANE_REGS; r++) begin
          if (rd_lane_hit[r]) begin
            prdata_next[7:0] = lane_sticky_reg[r];
          end
        end
      end else if (I_PADDR == byte_addr(IDX_SUMMARY)) begin
        prdata_next[7:0] = I_PWRITE ? 8'h00 : summary;
      end else if (I_PADDR == byte_addr(IDX_SYNC_SELECT)) begin
        prdata_next[7:0] = select_reg | {3'b000, cmm_reg, 4'h0};
      end else if (I_PADDR == byte_addr(IDX_THRESHOLD)) begin
        prdata_next[7:0] = threshold_reg;
      end else begin
        // Unmapped word answers with an error and zero data
        slverr_next = 1'b1;
      end
      if (!rd_setup) begin
        prdata_next = '0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PRDATA <= '0;
      slverr_reg <= 1'b0;
    end else begin
      O_PRDATA <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign O_PSLVERR = slverr_reg & O_PREADY;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_cmm_rise;
    config_mismatch_irq_enable && mismatch_rise;
  endsequence

  sequence s_irq_low;
    ##1 cmm_reg ##1 !O_IRQ_N;
  endsequence

  property p_unexpected_ctrl_char_summary;
    |ucc_reached && !wr_lane_hit[SLOT_UCC] |=> summary[SUM_UCC];
  endproperty
  a_unexpected_ctrl_char_summary: assert property (p_unexpected_ctrl_char_summary) else $error("ucc summary not set");

  property p_align_flag;
    |I_SYNC_FAIL.lane_align |=> summary[SUM_LANE_ALIGN];
  endproperty
  a_align_flag: assert property (p_align_flag) else $error("align summary not set");

  property p_chk_flag;
    |I_SYNC_FAIL.checksum |=> summary[SUM_CHECKSUM];
  endproperty
  a_chk_flag: assert property (p_chk_flag) else $error("checksum summary not set");

  property p_frame_flag;
    |I_SYNC_FAIL.frame |=> summary[SUM_FRAME];
  endproperty
  a_frame_flag: assert property (p_frame_flag) else $error("frame summary not set");

  property p_cgs_flag;
    |I_SYNC_FAIL.code_grp |=> summary[SUM_CODE_GRP];
  endproperty
  a_cgs_flag: assert property (p_cgs_flag) else $error("code group summary not set");

  property p_disp_resync;
    select_reg[SEL_DISP] && summary[SUM_DISP] |=> O_RESYNC_REQUEST;
  endproperty
  a_disp_resync: assert property (p_disp_resync) else $error("no disparity resync");

  property p_nit_resync;
    select_reg[SEL_NIT] && summary[SUM_NIT] |=> O_RESYNC_REQUEST;
  endproperty
  a_nit_resync: assert property (p_nit_resync) else $error("no symbol resync");

  property p_ucc_resync;
    !select_reg[SEL_DISP] && !select_reg[SEL_NIT] && !(select_reg[SEL_UCC] && summary[SUM_UCC])
      |=> !O_RESYNC_REQUEST;
  endproperty
  a_ucc_resync: assert property (p_ucc_resync) else $error("stray resync");

  property p_ucc_resync_set;
    select_reg[SEL_UCC] && summary[SUM_UCC] |=> O_RESYNC_REQUEST;
  endproperty
  a_ucc_resync_set: assert property (p_ucc_resync_set) else $error("no ctrl char resync");

  property p_cmm_irq;
    s_cmm_rise |-> s_irq_low;
  endproperty
  a_cmm_irq: assert property (p_cmm_irq) else $error("mismatch irq missing");

  property p_cmm_hold;
    cmm_reg && config_mismatch_irq_enable && !(wr_select && wr_byte[SEL_CMM]) |=> cmm_reg;
  endproperty
  a_cmm_hold: assert property (p_cmm_hold) else $error("mismatch bit dropped");

  property p_cmm_off;
    !config_mismatch_irq_enable |=> !cmm_reg;
  endproperty
  a_cmm_off: assert property (p_cmm_off) else $error("mismatch latched while off");

  property p_thresh_rst;
    $rose(I_RST_N) |-> threshold_reg == THRESHOLD_RST;
  endproperty
  a_thresh_rst: assert property (p_thresh_rst) else $error("threshold reset wrong");

  property p_frame_irq;
    mask_reg[SUM_FRAME] && summary[SUM_FRAME] |=> !O_IRQ_N;
  endproperty
  a_frame_irq: assert property (p_frame_irq) else $error("frame irq missing");

  property p_reserved;
    summary[SUM_RESERVED] == 1'b0 && mask_reg[SUM_RESERVED] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
endmodule

// *** sle_tx_model.sv ***
`timescale 1ns/1ps
module sle_tx_model import sle_pkg::*; (
  input wire logic i_clk,
  output logic [NUM_LANES-1:0] o_disp_err,
  output logic [NUM_LANES-1:0] o_nit_err,
  output logic [NUM_LANES-1:0] o_ucc_err,
  output sle_sync_fail_t o_sync_fail,
  output logic o_mismatch
);
  logic [31:0] sf;

  // ****************************************
  // Link side stimulus, all changes just after a rising edge
  // ****************************************
  assign o_sync_fail = sle_sync_fail_t'(sf);

  // Quiet link at time zero
  initial begin
    o_disp_err = '0;
    o_nit_err = '0;
    o_ucc_err = '0;
    sf = '0;
    o_mismatch = 1'b0;
  end

  // Drive one counted strobe of a kind: 0 disparity, 1 symbol, 2 control char
  task automatic put(input int kind, input int lane, input logic v);
    case (kind)
      0: o_disp_err[lane] <= v;
      1: o_nit_err[lane] <= v;
      default: o_ucc_err[lane] <= v;
    endcase
  endtask

  // Each high cycle is one error; spaced mode mimics a slow, bursty link
  task automatic burst(input int kind, input int lane, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      put(kind, lane, 1'b1);
      if (gap != 0) begin
        @(posedge i_clk);
        put(kind, lane, 1'b0);
      end
    end
    @(posedge i_clk);
    put(kind, lane, 1'b0);
  endtask

  // One-cycle sync failure; kind follows the summary bit order
  task automatic sync_pulse(input int kind, input int lane);
    @(posedge i_clk);
    sf[kind * NUM_LANES + lane] <= 1'b1;
    @(posedge i_clk);
    sf <= '0;
  endtask

  // Configuration mismatch is a level, its rise is the event
  task automatic set_mismatch(input logic v);
    @(posedge i_clk);
    o_mismatch <= v;
  endtask
endmodule

// *** serial_link_error_irq_sync_tb_top.sv ***
`timescale 1ns/1ps
module serial_link_error_irq_sync_tb_top import sle_pkg::*;;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sle_sync_fail_t sync_fail;
  logic [NUM_LANES-1:0] disp;
  logic [NUM_LANES-1:0] nit;
  logic [NUM_LANES-1:0] ucc;
  logic mism;
  logic irq_n;
  logic resync;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'h0000_e0a4;
  int lane;
  int o;
  logic [31:0] rd;
  logic err;
  logic [7:0] thr;

  sle_irq_sync dut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SYNC_FAIL(sync_fail), .I_DISP_ERR(disp),
    .I_NIT_ERR(nit), .I_UCC_ERR(ucc), .I_CONFIG_MISMATCH(mism), .O_IRQ_N(irq_n),
    .O_RESYNC_REQUEST(resync));

  sle_tx_model tx (.i_clk(clk), .o_disp_err(disp), .o_nit_err(nit), .o_ucc_err(ucc),
    .o_sync_fail(sync_fail), .o_mismatch(mism));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Interrupt level expected from flags, mask and latched mismatch
  function automatic logic exp_irq_n(input logic [7:0] sum, input logic [7:0] msk,
    input logic config_mismatch_latched);
    return !((|(sum & msk & 8'hef)) || config_mismatch_latched);
  endfunction

  // One APB transfer; waits for pready, only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp, what);
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    chk(32'h0000_0000, 32'h0000_0001, "timeout");
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped address
    rdchk(IDX_THRESHOLD, 32'h0000_00ff, "threshold reset");
    rdchk(IDX_SYNC_SELECT, 32'h0000_0008, "select reset");
    rdchk(IDX_SUMMARY, 32'h0000_0000, "summary reset");
    apb(1'b0, 12'h0400, 8'h00);
    chk(err, 1'b1, "unmapped error");
    chk(irq_n, 1'b1, "irq reset");
    // Sync failures: masked, unmasked, cleared
    for (int k = 0; k < 4; k++) begin
      lane = $unsigned($random(seed)) % NUM_LANES;
      tx.sync_pulse(k, lane);
      repeat (3) @(posedge clk);
      chk(irq_n, exp_irq_n(8'h01 << k, 8'h00, 1'b0), "masked irq");
      rdchk(IDX_SUMMARY, 32'h0000_0001 << k, "sync summary");
      rdchk(12'(IDX_CODE_GRP_LANES + k), 32'h0000_0001 << lane, "sync lanes");
      apb(1'b1, IDX_SUMMARY, 8'h01 << k);
      repeat (3) @(posedge clk);
      chk(irq_n, exp_irq_n(8'h01 << k, 8'h01 << k, 1'b0), "unmasked irq");
      apb(1'b1, 12'(IDX_CODE_GRP_LANES + k), 8'h01 << lane);
      repeat (3) @(posedge clk);
      chk(irq_n, 1'b1, "irq after clear");
    end
    // Counted errors against a random threshold; only the selected type resyncs
    for (int j = 0; j < 6; j++) begin
      int k;
      k = j % 3;
      o = (k + 1) % 3;
      thr = 8'($unsigned($random(seed)) % 6 + 1);
      lane = $unsigned($random(seed)) % NUM_LANES;
      apb(1'b1, IDX_THRESHOLD, thr);
      apb(1'b1, IDX_SYNC_SELECT, 8'h08 | (8'h80 >> k));
      tx.burst(k, lane, int'(thr) - 1, $random(seed) & 1);
      tx.burst(o, lane, int'(thr), 0);
      repeat (3) @(posedge clk);
      chk(resync, 1'b0, "early resync");
      rdchk(IDX_SUMMARY, 32'h0000_0080 >> o, "below threshold");
      tx.burst(k, lane, 1, 0);
      repeat (3) @(posedge clk);
      chk(resync, 1'b1, "resync at threshold");
      rdchk(IDX_SUMMARY, (32'h0000_0080 >> o) | (32'h0000_0080 >> k), "counted");
      rdchk(12'(IDX_DISP_LANES + k), 32'h0000_0001 << lane, "count lanes");
      chk(irq_n, 1'b1, "counted masked");
      apb(1'b1, 12'(IDX_DISP_LANES + k), 8'h01 << lane);
      apb(1'b1, 12'(IDX_DISP_LANES + o), 8'h01 << lane);
      repeat (3) @(posedge clk);
      chk(resync, 1'b0, "resync released");
    end
    // Configuration mismatch latched, held, cleared, then disabled
    apb(1'b1, IDX_SYNC_SELECT, 8'h08);
    tx.set_mismatch(1'b1);
    repeat (3) @(posedge clk);
    chk(irq_n, 1'b0, "mismatch irq");
    tx.set_mismatch(1'b0);
    rdchk(IDX_SYNC_SELECT, 32'h0000_0018, "mismatch held");
    apb(1'b1, IDX_SYNC_SELECT, 8'h18);
    rdchk(IDX_SYNC_SELECT, 32'h0000_0008, "mismatch cleared");
    chk(irq_n, 1'b1, "irq after w1c");
    apb(1'b1, IDX_SYNC_SELECT, 8'h00);
    tx.set_mismatch(1'b1);
    repeat (3) @(posedge clk);
    chk(irq_n, 1'b1, "disabled mismatch");
    rdchk(IDX_SYNC_SELECT, 32'h0000_0000, "no latch");
    tx.set_mismatch(1'b0);
    // Reserved bits: summary bit 4 and select bits 2:0
    apb(1'b1, IDX_SUMMARY, 8'hff);
    tx.sync_pulse(3, 0);
    repeat (3) @(posedge clk);
    rdchk(IDX_SUMMARY, 32'h0000_0008, "reserved flag");
    chk(irq_n, 1'b0, "align irq");
    apb(1'b1, IDX_SYNC_SELECT, 8'hff);
    rdchk(IDX_SYNC_SELECT, 32'h0000_00e8, "select reserved");
    end_of_test();
  end
endmodule
